// ### wdts_pkg.sv
package wdts_pkg;

  // ==========================================================================
  // Register map (byte addresses on the Wishbone bus, one 32-bit word apart)
  // ==========================================================================
  localparam logic [3:0] WDTS_ADDR_CONTROL = 4'h0;  // watchdog_control
  localparam logic [3:0] WDTS_ADDR_STATUS  = 4'h4;  // Sleep/time-out status
  localparam logic [3:0] WDTS_ADDR_CAUSE   = 4'h8;  // reset_cause_register

  // Control register fields
  localparam int         WDTS_EN_BIT       = 0;
  localparam int         WDTS_PS_LSB       = 1;
  localparam int         WDTS_PS_MSB       = 5;
  localparam logic [4:0] WDTS_PS_RESET     = 5'h0b;
  localparam logic [4:0] WDTS_PS_MAX       = 5'h12;
  localparam logic [4:0] WDTS_PS_OFFSET    = 5'h05;
  localparam logic       WDTS_EN_RESET     = 1'b0;

  // Status and reset-cause register fields
  localparam int         WDTS_TO_BIT       = 1;
  localparam int         WDTS_PD_BIT       = 0;
  localparam int         WDTS_WATCHDOG_RESET_CAUSE_FLAG_BIT     = 4;

  // Mode configuration codes
  localparam logic [1:0] WDTS_MODE_OFF     = 2'h0;
  localparam logic [1:0] WDTS_MODE_SOFT    = 2'h1;
  localparam logic [1:0] WDTS_MODE_NOSLEEP = 2'h2;
  localparam logic [1:0] WDTS_MODE_ON      = 2'h3;

  // Counter width: highest ratio is 2^23
  localparam int         WDTS_CNT_W        = 24;

  // Power states, one-hot
  typedef enum logic [2:0] {
    WDTS_ST_INIT  = 3'b001,
    WDTS_ST_AWAKE = 3'b010,
    WDTS_ST_SLEEP = 3'b100
  } wdts_state_t;

endpackage

// ### wdts_sync.sv
`timescale 1ns/100ps
// Two-flop synchroniser for the oscillator input; the event pins are not synchronised
module wdts_sync (
  input  wire logic sys_clk,
  input  wire logic rst,
  input  wire logic async_in,
  output logic      sync_out
);
  logic meta_q;

  // ==========================================================================
  // Synchroniser chain; first stage is read only by the second
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      meta_q   <= 1'b0;
      sync_out <= 1'b0;
    end else begin
      meta_q   <= async_in;
      sync_out <= meta_q;
    end
  end
endmodule // wdts_sync

// ### wdts_top.sv
// Added by the designer: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/100ps
// Function
// R1: Raise system reset when count reaches selected period without a clear.
// R2: Time base is the independent low-frequency oscillator, not the core clock.
// R3: Mode 11 keeps watchdog active always, sleep included, ignoring soft enable.
// R4: Mode 10 runs while awake, stops in sleep, ignores soft enable.
// R5: Mode 01 lets the soft enable bit switch the watchdog; sleep irrelevant.
// R6: Mode 00 keeps watchdog disabled; soft enable has no effect.
// R7: Period code sets ratio to two to the power of code plus five.
// R8: Reserved period codes above 10010 behave as minimum ratio 1:32.
// R9: Period select resets to code 01011, a two-second time-out.
// R10: Counter clears on reset, clear, sleep entry, wake, oscillator fail, disable.
// R11: Oscillator divider changes leave the watchdog count untouched.
// R12: Enabled in sleep, counting restarts from zero and clears again on wake.
// R13: Time-out in sleep wakes the core and updates time-out and power-down flags.
// R14: A watchdog reset sets the watchdog reset-cause flag.
// R15: Control bits 7:6 read zero, 5:1 period select, 0 soft enable resetting zero.
// R16: Mode configuration is sampled at reset and held constant afterwards.
module wdts_top
  import wdts_pkg::*;
(
  input  wire logic        sys_clk,
  input  wire logic        rst,
  // Wishbone classic slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic [31:0]      wb_dat_o,
  output logic             wb_ack_o,
  // Core and system events
  input  wire logic        low_freq_internal_osc,
  input  wire logic [1:0]  watchdog_mode_config,
  input  wire logic        watchdog_clear_instruction,
  input  wire logic        sleep_instruction,
  input  wire logic        wake_event,
  input  wire logic        osc_fail,
  input  wire logic [3:0]  internal_osc_divider_select,
  output logic             watchdog_reset,
  output logic             watchdog_wake,
  output logic             in_sleep
);
  import wdts_pkg::*;

  // ==========================================================================
  // Declarations
  // ==========================================================================
  logic                  osc_s;
  logic                  osc_prev_q;
  logic                  tick;
  logic [1:0]            mode_q;
  logic                  en_q;
  logic [4:0]            ps_q;
  logic [4:0]            ps_eff;
  logic [WDTS_CNT_W-1:0] cnt_q;
  logic [WDTS_CNT_W-1:0] limit;
  logic                  active;
  logic                  expire;
  logic                  clr_evt;
  logic                  sleep_go;
  logic                  wake_go;
  logic                  to_flag_q;
  logic                  pd_flag_q;
  logic                  watchdog_reset_cause_flag_q;
  logic                  active_prev_q;
  logic                  wb_hit;
  logic                  wr_ctl;
  wdts_state_t           st_q;
  wdts_state_t           st_d;

  // ==========================================================================
  // Oscillator tick
  // ==========================================================================
  // Oscillator is asynchronous to sys_clk, so it is synchronised first
  wdts_sync i_wdts_sync (
    .sys_clk  (sys_clk),
    .rst      (rst),
    .async_in (low_freq_internal_osc),
    .sync_out (osc_s)
  );

  // Rising edge of the synchronised oscillator is one time-base tick
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      osc_prev_q <= 1'b0;
    end else begin
      osc_prev_q <= osc_s;
    end
  end
  assign tick = osc_s & ~osc_prev_q; // R2

  // ==========================================================================
  // Mode strap
  // ==========================================================================
  // Sampled during reset by a clocked process and frozen after release
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      mode_q <= watchdog_mode_config; // R16
    end
  end

  // ==========================================================================
  // Power state machine
  // ==========================================================================
  assign sleep_go = (st_q == WDTS_ST_AWAKE) && sleep_instruction;
  assign wake_go  = (st_q == WDTS_ST_SLEEP) && (wake_event || expire);

  // Next power state
  always_comb begin
    st_d = st_q;
    case (st_q)
      WDTS_ST_INIT: begin
        st_d = WDTS_ST_AWAKE;
      end
      WDTS_ST_AWAKE: begin
        if (sleep_go) begin
          st_d = WDTS_ST_SLEEP;
        end
      end
      WDTS_ST_SLEEP: begin
        if (wake_go) begin
          st_d = WDTS_ST_AWAKE; // R13
        end
      end
      default: begin
        st_d = WDTS_ST_INIT;
      end
    endcase
  end

  // Power state register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= WDTS_ST_INIT;
    end else begin
      st_q <= st_d;
    end
  end
  assign in_sleep = (st_q == WDTS_ST_SLEEP);

  // ==========================================================================
  // Enable decode
  // ==========================================================================
  always_comb begin
    case (mode_q)
      WDTS_MODE_ON:      active = 1'b1;               // R3
      WDTS_MODE_NOSLEEP: active = ~in_sleep;          // R4
      WDTS_MODE_SOFT:    active = en_q;               // R5
      default:           active = 1'b0;               // R6
    endcase
  end

  // ==========================================================================
  // Period select
  // ==========================================================================
  // Reserved codes fold to the shortest ratio
  assign ps_eff = (ps_q > WDTS_PS_MAX) ? 5'h00 : ps_q; // R8
  // Time-out count is 2^(code+5) oscillator ticks
  assign limit  = WDTS_CNT_W'(1) << (ps_eff + WDTS_PS_OFFSET); // R7

  // ==========================================================================
  // Counter
  // ==========================================================================
  // Divider select is not an input to this logic, so it cannot disturb it
  assign clr_evt = watchdog_clear_instruction | sleep_go | wake_go |
                   osc_fail | ~active; // R10 R11
  // A count already past a newly shortened period expires on its next tick
  assign expire  = active && tick && (cnt_q >= limit - WDTS_CNT_W'(1)); // R1

  // Count ticks, restarting on every clearing event
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      cnt_q <= '0; // R10
    end else if (clr_evt || expire) begin
      cnt_q <= '0; // R12
    end else if (tick) begin
      cnt_q <= cnt_q + WDTS_CNT_W'(1);
    end
  end

  // ==========================================================================
  // Reset and wake outputs
  // ==========================================================================
  // Awake expiry resets the system; sleep expiry only wakes the core
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      watchdog_reset <= 1'b0;
      watchdog_wake  <= 1'b0;
    end else begin
      watchdog_reset <= expire && !in_sleep && !clr_evt; // R1
      watchdog_wake  <= expire && in_sleep;              // R13
    end
  end

  // ==========================================================================
  // Status flags
  // ==========================================================================
  // Time-out and power-down flags; a sleep expiry clears time-out
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      to_flag_q <= 1'b1;
      pd_flag_q <= 1'b1;
    end else if (expire && in_sleep) begin
      to_flag_q <= 1'b0; // R13
      pd_flag_q <= 1'b0;
    end else if (sleep_go) begin
      to_flag_q <= 1'b1;
      pd_flag_q <= 1'b0;
    end else if (watchdog_clear_instruction) begin
      to_flag_q <= 1'b1;
      pd_flag_q <= 1'b1;
    end
  end

  // Reset cause is set by watchdog_reset and cleared by rst; software writes
  // a one to clear, but a new watchdog reset wins over that write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      watchdog_reset_cause_flag_q <= 1'b0;
    end else if (watchdog_reset) begin
      watchdog_reset_cause_flag_q <= 1'b1; // R14
    end else if (wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] &&
                 wb_adr_i == WDTS_ADDR_CAUSE && wb_dat_i[WDTS_WATCHDOG_RESET_CAUSE_FLAG_BIT]) begin
      watchdog_reset_cause_flag_q <= 1'b0;
    end
  end

  // ==========================================================================
  // Wishbone slave
  // ==========================================================================
  assign wb_hit = wb_cyc_i && wb_stb_i && !wb_ack_o;
  // Writes land at the edge where the master samples ack, not when the cycle is taken
  assign wr_ctl = wb_cyc_i && wb_stb_i && wb_ack_o && wb_we_i && wb_sel_i[0] && (wb_adr_i == WDTS_ADDR_CONTROL);

  // Control register write
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ps_q <= WDTS_PS_RESET; // R9
      en_q <= WDTS_EN_RESET; // R15
    end else if (wr_ctl) begin
      ps_q <= wb_dat_i[WDTS_PS_MSB:WDTS_PS_LSB]; // R15
      en_q <= wb_dat_i[WDTS_EN_BIT];
    end
  end

  // One-cycle ack with registered read data; unmapped reads return zero
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= '0;
    end else begin
      wb_ack_o <= wb_hit;
      wb_dat_o <= '0;
      if (wb_hit && !wb_we_i) begin
        case (wb_adr_i)
          WDTS_ADDR_CONTROL: begin
            wb_dat_o[WDTS_PS_MSB:WDTS_PS_LSB] <= ps_q; // R15
            wb_dat_o[WDTS_EN_BIT]             <= en_q;
          end
          WDTS_ADDR_STATUS: begin
            wb_dat_o[WDTS_TO_BIT] <= to_flag_q;
            wb_dat_o[WDTS_PD_BIT] <= pd_flag_q;
          end
          WDTS_ADDR_CAUSE: begin
            wb_dat_o[WDTS_WATCHDOG_RESET_CAUSE_FLAG_BIT] <= watchdog_reset_cause_flag_q;
          end
          default: begin
            wb_dat_o <= '0;
          end
        endcase
      end
    end
  end

  // ==========================================================================
  // Assertions
  // ==========================================================================
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      active_prev_q <= 1'b0;
    end else begin
      active_prev_q <= active;
    end
  end

  sequence clr_seen_s;
    watchdog_clear_instruction;
  endsequence

  mode_strap_a: assert property (@(posedge sys_clk) disable iff (rst) // R16
    $stable(mode_q)) else $error("mode changed after reset");
  mode_off_a: assert property (@(posedge sys_clk) disable iff (rst) // R6
    mode_q == WDTS_MODE_OFF |-> !active && cnt_q == '0) else $error("watchdog active in off mode");
  mode_on_a: assert property (@(posedge sys_clk) disable iff (rst) // R3
    mode_q == WDTS_MODE_ON |-> active) else $error("watchdog idle in always-on mode");
  sleep_off_a: assert property (@(posedge sys_clk) disable iff (rst) // R4
    mode_q == WDTS_MODE_NOSLEEP && in_sleep |-> !active) else $error("watchdog active in sleep");
  soft_en_a: assert property (@(posedge sys_clk) disable iff (rst) // R5
    mode_q == WDTS_MODE_SOFT |-> active == en_q) else $error("soft enable ignored");
  clear_cnt_a: assert property (@(posedge sys_clk) disable iff (rst) // R10
    clr_seen_s |=> cnt_q == '0) else $error("clear did not zero count");
  disable_cnt_a: assert property (@(posedge sys_clk) disable iff (rst) // R10
    active_prev_q && !active |-> ##1 cnt_q == '0) else $error("disable did not zero count");
  reserved_ps_a: assert property (@(posedge sys_clk) disable iff (rst) // R8
    ps_q > WDTS_PS_MAX |-> limit == (WDTS_CNT_W'(1) << WDTS_PS_OFFSET)) else $error("reserved code not minimum");
  expire_reset_a: assert property (@(posedge sys_clk) disable iff (rst) // R1
    expire && !in_sleep && !clr_evt |=> watchdog_reset ##1 watchdog_reset_cause_flag_q) else $error("expiry did not reset");
  sleep_wake_a: assert property (@(posedge sys_clk) disable iff (rst) // R13
    expire && in_sleep |=> watchdog_wake && !watchdog_reset && !to_flag_q && !in_sleep)
    else $error("sleep expiry mishandled");
  sleep_entry_a: assert property (@(posedge sys_clk) disable iff (rst) // R12
    sleep_go |=> cnt_q == '0 && in_sleep) else $error("sleep entry did not clear");
  ps_reset_a: assert property (@(posedge sys_clk) // R9
    $fell(rst) |-> ps_q == WDTS_PS_RESET && !en_q) else $error("period reset value wrong");

  // Awake expiry: a one-cycle reset pulse, then the cause flag
  sequence awake_expiry_s;
    expire && !in_sleep && !clr_evt;
  endsequence

  sequence reset_pulse_s;
    watchdog_reset ##1 (!watchdog_reset && watchdog_reset_cause_flag_q);
  endsequence

  // Sleep expiry: a one-cycle wake pulse with the core already awake
  sequence sleep_expiry_s;
    expire && in_sleep;
  endsequence

  sequence wake_pulse_s;
    (watchdog_wake && !in_sleep) ##1 !watchdog_wake;
  endsequence

  reset_pulse_a: assert property (@(posedge sys_clk) disable iff (rst) // R1 R14
    awake_expiry_s |=> reset_pulse_s) else $error("reset pulse malformed");
  wake_pulse_a: assert property (@(posedge sys_clk) disable iff (rst) // R13
    sleep_expiry_s |=> wake_pulse_s) else $error("wake pulse malformed");
  fail_clear_a: assert property (@(posedge sys_clk) disable iff (rst) // R10
    osc_fail |=> cnt_q == '0) else $error("oscillator fail did not clear");
  wake_clear_a: assert property (@(posedge sys_clk) disable iff (rst) // R12
    wake_go |=> cnt_q == '0 && !in_sleep) else $error("wake did not clear");
  tick_only_a: assert property (@(posedge sys_clk) disable iff (rst) // R2
    !tick && !clr_evt |=> $stable(cnt_q)) else $error("count moved without a tick");
  div_indep_a: assert property (@(posedge sys_clk) disable iff (rst) // R11
    $changed(internal_osc_divider_select) && !clr_evt && !tick |=> $stable(cnt_q))
    else $error("divider change disturbed count");
endmodule // wdts_top

// ### wdts_core_model.sv
`timescale 1ns/100ps
// ====================
// Core side: oscillator and instruction strobes
module wdts_core_model (
  input  wire logic sys_clk,
  output logic      osc,
  output logic      clr,
  output logic      slp,
  output logic      wake,
  output logic      fail
);
  logic [3:0] strb_q;

  // Strobes: clear, sleep, wake, oscillator fail
  assign {fail, wake, slp, clr} = strb_q;

  // Free-running and phase-unrelated to sys_clk
  // Sped up so that the long counts fit in the run
  initial begin
    osc = 1'b0;
    strb_q = 4'h0;
    forever #201.5 osc = ~osc;
  end

  // One-cycle strobe, changed only just after rising edges
  task automatic pulse(input int k);
    @(posedge sys_clk);
    strb_q <= 4'(4'h1 << k);
    @(posedge sys_clk);
    strb_q <= 4'h0;
  endtask
endmodule // wdts_core_model

// ### tb_watchdog_timer_with_sleep_modes.sv
`timescale 1ns/100ps
// ====================
// Bench
module tb_watchdog_timer_with_sleep_modes;
  import wdts_pkg::*;
  logic        sys_clk, rst, cyc, stb, we, ack, osc, clr, slp, wake, fail, wdr, wdw, insl;
  logic [1:0]  mode;
  logic [3:0]  adr, sel, div;
  logic [31:0] wdat, dat_o;
  logic [4:0]  codes [4] = '{5'h00, 5'h01, 5'h13, 5'h1f};
  int          exps [4] = '{32, 64, 32, 32};
  int          mismatches, cmp_count, ticks;

  wdts_top i_wdts_top (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .low_freq_internal_osc(osc), .watchdog_mode_config(mode), .watchdog_clear_instruction(clr),
    .sleep_instruction(slp), .wake_event(wake), .osc_fail(fail), .internal_osc_divider_select(div),
    .watchdog_reset(wdr), .watchdog_wake(wdw), .in_sleep(insl));

  wdts_core_model i_wdts_core_model (.sys_clk(sys_clk), .osc(osc), .clr(clr), .slp(slp),
    .wake(wake), .fail(fail));

  // ====================
  // Clock and oscillator tick count
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  always @(posedge osc) ticks++;

  // ====================
  // Tasks
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Classic single cycle; held until ack is sampled high
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge sys_clk);
    {cyc, stb, we} <= {2'b11, w};
    adr <= a;
    wdat <= d;
    do begin
      @(posedge sys_clk);
    end while (ack !== 1'b1);
    q = dat_o;
    {cyc, stb, we} <= 3'b000;
  endtask

  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q, e);
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask

  // Mode strap only counts while reset is applied
  task automatic restart(input logic [1:0] m);
    @(posedge sys_clk);
    mode <= m;
    rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
  endtask

  // Strobe k midway between oscillator edges, so no tick is caught in the synchroniser,
  // then count ticks up to expiry; exp 0 means no expiry is allowed
  task automatic run(input int k, input int exp, input logic wakeup);
    int n;
    @(posedge osc);
    repeat (4) @(posedge sys_clk);
    ticks = 0;
    i_wdts_core_model.pulse(k);
    n = 0;
    while (wdr !== 1'b1 && wdw !== 1'b1 && n < 1200) begin
      @(posedge sys_clk);
      n++;
      if (n == 100) div <= ~div;
    end
    chk((n < 1200) ? ticks : 0, exp);
    if (exp != 0) chk({31'h0, wdw}, {31'h0, wakeup});
  endtask

  task automatic tend(input string s);
    $display("test %s done", s);
  endtask

  // ====================
  // Tests
  initial begin
    {rst, cyc, stb, we} = 4'b1000;
    mode = WDTS_MODE_ON;
    adr = 4'h0;
    sel = 4'h1;
    div = 4'h0;
    wdat = 32'h0;
    repeat (2) @(posedge sys_clk);
    rst <= 1'b0;
    rd(WDTS_ADDR_CONTROL, 32'h16);
    rd(WDTS_ADDR_STATUS, 32'h3);
    rd(WDTS_ADDR_CAUSE, 32'h0);
    rd(4'hc, 32'h0);
    wr(WDTS_ADDR_CONTROL, 32'hff);
    rd(WDTS_ADDR_CONTROL, 32'h3f);
    tend("registers");
    for (int i = 0; i < 4; i++) begin
      wr(WDTS_ADDR_CONTROL, {26'h0, codes[i], 1'b0});
      run(0, exps[i], 1'b0);
    end
    rd(WDTS_ADDR_CAUSE, 32'h10);
    wr(WDTS_ADDR_CAUSE, 32'h10);
    rd(WDTS_ADDR_CAUSE, 32'h0);
    run(3, 32, 1'b0);
    run(1, 32, 1'b1);
    chk({31'h0, insl}, 32'h0);
    rd(WDTS_ADDR_STATUS, 32'h0);
    tend("always on");
    restart(WDTS_MODE_NOSLEEP);
    wr(WDTS_ADDR_CONTROL, 32'h0);
    run(0, 32, 1'b0);
    run(1, 0, 1'b0);
    rd(WDTS_ADDR_STATUS, 32'h2);
    i_wdts_core_model.pulse(2);
    repeat (3) @(posedge sys_clk);
    chk({31'h0, insl}, 32'h0);
    run(0, 32, 1'b0);
    tend("off in sleep");
    restart(WDTS_MODE_SOFT);
    wr(WDTS_ADDR_CONTROL, 32'h0);
    run(0, 0, 1'b0);
    wr(WDTS_ADDR_CONTROL, 32'h1);
    run(0, 32, 1'b0);
    run(1, 32, 1'b1);
    tend("software");
    restart(WDTS_MODE_OFF);
    wr(WDTS_ADDR_CONTROL, 32'h1);
    run(0, 0, 1'b0);
    @(posedge sys_clk);
    mode <= WDTS_MODE_ON;
    run(0, 0, 1'b0);
    tend("always off");
    conclude();
  end

  // Hang guard, well beyond the whole sequence
  initial begin
    repeat (60000) @(posedge sys_clk);
    mismatches++;
    conclude();
  end
endmodule // tb_watchdog_timer_with_sleep_modes
